// [design/fpl_debounce.sv]
`timescale 1ns/100ps
// synchronises and debounces the pushbutton, gives one pulse per press
module fpl_debounce
    import fpl_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // raw button and clean press pulse
    input wire logic button_in,
    output logic press_out
);
    logic sync_a;
    logic sync_b;
    logic stable;
    logic [FPL_DB_W-1:0] count;

    // count settle time on a changed synchronised level
    wire differs = sync_b != stable;
    wire settled = count == FPL_DB_W'(FPL_DEBOUNCE_CYC - 1);

    // two-flop synchroniser, then settle counter
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            stable <= 1'b0;
            count <= '0;
            press_out <= 1'b0;
        end
        else
        begin
            sync_a <= button_in;
            sync_b <= sync_a;
            count <= (differs && !settled) ? count + 1'b1 : '0;
            if (differs && settled)
                stable <= sync_b;
            press_out <= differs && settled && sync_b;
        end
    end

    // a press pulse is always a single cycle
    press_single_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        press_out |=> !press_out)
        else $error("press pulse too long");
endmodule

// [design/fpl_panel.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module fpl_panel
    import fpl_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // front panel switches
    input wire logic clear_mode_switch_in,
    input wire logic load_mode_switch_in,
    input wire logic direction_switch_in,
    input wire logic entry_pushbutton_in,
    input wire logic [7:0] byte_entry_switches_in,
    // power header controls
    input wire logic clock_gate_in,
    input wire logic lamp_enable_n_in,
    input wire logic gpio_mode_in,
    // processor core side
    input wire logic core_flag_in,
    input wire logic core_out_strobe_in,
    input wire logic [7:0] core_out_data_in,
    input wire logic mem_rdata_valid_in,
    input wire logic [7:0] mem_rdata_in,
    output logic core_reset_out,
    output logic core_halt_out,
    output logic core_clk_en_out,
    output fpl_mem_req_t mem_req_out,
    // lamps and connector
    output logic [7:0] byte_display_lamps_out,
    output logic flag_lamp_out,
    output logic [7:0] connector_gpio_out,
    output logic connector_gpio_oe_n_out,
    output fpl_mode_t mode_out,
    output logic [15:0] register_zero_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic press;
    logic [15:0] register_zero;
    logic [7:0] shown;
    logic read_pending;
    logic [7:0] port_latch;

    fpl_debounce u_debounce
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .button_in(entry_pushbutton_in),
        .press_out(press)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mode decode: clear/load switches, up = 1
    wire [1:0] sw = {clear_mode_switch_in, load_mode_switch_in};
    wire fpl_mode_t next_mode = (sw == 2'b00) ? FPL_MODE_LOAD :
        (sw == 2'b01) ? FPL_MODE_CLEAR :
        (sw == 2'b10) ? FPL_MODE_WAIT : FPL_MODE_RUN;
    wire in_load = next_mode == FPL_MODE_LOAD;
    wire in_clear = next_mode == FPL_MODE_CLEAR;
    wire in_run = next_mode == FPL_MODE_RUN;
    // program output bytes count only while the program runs
    wire run_out = core_out_strobe_in && in_run;
    wire access = in_load && press && !read_pending;
    wire do_write = access && direction_switch_in;
    wire do_read = access && !direction_switch_in;
    wire read_done = read_pending && mem_rdata_valid_in;
    wire [15:0] next_addr = register_zero + FPL_ADDR_STEP;
    wire lamps_on = !lamp_enable_n_in;

    ////////////////////////////////////////////////////////////////////////////
    // register zero: cleared in clear, stepped after each write and after each read whose data returns in load mode
    always_ff @(posedge clk_in)
    begin
        if (rst_in || in_clear)
            register_zero <= FPL_ADDR_RST;
        else if (do_write || read_done)
            register_zero <= next_addr;
    end

    // read tracking and shown byte
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            read_pending <= 1'b0;
            shown <= FPL_BYTE_RST;
            port_latch <= FPL_BYTE_RST;
        end
        else
        begin
            // a pending read survives only while load mode stands
            read_pending <= in_load
                && (do_read || (read_pending && !read_done));
            if (do_write)
                shown <= byte_entry_switches_in;
            else if (read_done)
                shown <= mem_rdata_in;
            else if (run_out)
                shown <= core_out_data_in;
            if (run_out)
                port_latch <= core_out_data_in;
        end
    end

    // registered outputs
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            mode_out <= FPL_MODE_CLEAR;
            core_reset_out <= 1'b1;
            core_halt_out <= 1'b0;
            core_clk_en_out <= 1'b0;
            mem_req_out <= '0;
            byte_display_lamps_out <= FPL_BYTE_RST;
            flag_lamp_out <= 1'b0;
            connector_gpio_out <= FPL_BYTE_RST;
            connector_gpio_oe_n_out <= 1'b1;
            register_zero_out <= FPL_ADDR_RST;
        end
        else
        begin
            mode_out <= next_mode;
            core_reset_out <= in_clear;
            core_halt_out <= !in_run && !in_clear;
            core_clk_en_out <= clock_gate_in;
            mem_req_out.req <= access;
            mem_req_out.write <= do_write;
            mem_req_out.addr <= register_zero;
            mem_req_out.data <= byte_entry_switches_in;
            byte_display_lamps_out <= lamps_on ? shown : 8'h00;
            flag_lamp_out <= lamps_on && core_flag_in && !in_clear;
            connector_gpio_out <= gpio_mode_in ? port_latch : 8'h00;
            connector_gpio_oe_n_out <= !gpio_mode_in;
            register_zero_out <= register_zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode checks: decode, reset, halt and clock gate
    mode_decode_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (sw == 2'b00) |=> mode_out == FPL_MODE_LOAD)
        else $error("load mode not decoded");
    clear_reset_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        in_clear |=> core_reset_out ##1 register_zero_out == 16'h0000)
        else $error("clear did not zero");
    wait_halt_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (sw == 2'b10) |=> core_halt_out && !core_reset_out)
        else $error("wait did not halt");
    run_free_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (sw == 2'b11) |=> !core_halt_out && !core_reset_out)
        else $error("run held core");
    clk_gate_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        1'b1 |=> core_clk_en_out == $past(clock_gate_in))
        else $error("clock gate wrong");

    // access checks: one request per press, direction, data, pointer
    no_idle_access_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        !press |=> !mem_req_out.req)
        else $error("access without press");
    busy_refuse_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        read_pending |=> !mem_req_out.req)
        else $error("access while read pending");
    write_dir_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        do_write |=> mem_req_out.req && mem_req_out.write)
        else $error("write direction wrong");
    read_dir_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        do_read |=> mem_req_out.req && !mem_req_out.write)
        else $error("read direction wrong");
    write_data_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        do_write |=> mem_req_out.data == $past(byte_entry_switches_in))
        else $error("wrong entry byte");
    write_step_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        do_write |=> register_zero == $past(register_zero) + 16'h0001)
        else $error("pointer not stepped");
    read_step_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (read_done && !in_clear)
            |=> register_zero == $past(register_zero) + 16'h0001)
        else $error("pointer not stepped after read");
    read_show_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (read_done && !core_out_strobe_in) |=> shown == $past(mem_rdata_in))
        else $error("read byte not shown");

    // lamp and connector checks
    run_show_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (run_out && !read_done) |=> shown == $past(core_out_data_in))
        else $error("program byte not shown");
    lamp_dark_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        lamp_enable_n_in |=> byte_display_lamps_out == 8'h00 && !flag_lamp_out)
        else $error("lamps lit while disabled");
    flag_lamp_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (!lamp_enable_n_in && !in_clear)
            |=> flag_lamp_out == $past(core_flag_in))
        else $error("flag lamp wrong");
    gpio_route_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        !gpio_mode_in |=> connector_gpio_oe_n_out)
        else $error("gpio driven in parallel mode");
    gpio_data_a: assert property (@(posedge clk_in)
        disable iff (rst_in)
        gpio_mode_in |=> connector_gpio_out == $past(port_latch))
        else $error("gpio byte wrong");

    // main scenarios
    cover_write_c: cover property (@(posedge clk_in) do_write);
    cover_read_c: cover property (@(posedge clk_in) read_done);
    cover_run_out_c: cover property (@(posedge clk_in) run_out);
    cover_wait_run_c: cover property (@(posedge clk_in)
        next_mode == FPL_MODE_WAIT ##1 next_mode == FPL_MODE_RUN);
    cover_refused_c: cover property (@(posedge clk_in) press && !in_load);
endmodule

// [design/fpl_pkg.sv]
package fpl_pkg;
    // panel modes, gray coded along clear, load, run, wait
    typedef enum logic [1:0] {
        FPL_MODE_CLEAR = 2'b00,
        FPL_MODE_LOAD = 2'b01,
        FPL_MODE_RUN = 2'b11,
        FPL_MODE_WAIT = 2'b10
    } fpl_mode_t;

    // processor-side request carried to the core
    typedef struct packed {
        logic req;
        logic write;
        logic [15:0] addr;
        logic [7:0] data;
    } fpl_mem_req_t;

    // widths and reset values
    localparam int FPL_AW = 16;
    localparam logic [15:0] FPL_ADDR_RST = 16'h0000;
    localparam logic [15:0] FPL_ADDR_STEP = 16'h0001;
    localparam logic [7:0] FPL_BYTE_RST = 8'h00;

    // debounce: button must stand still this long
    localparam int FPL_CLK_MHZ = 250;
    localparam int FPL_DEBOUNCE_US = 10;
    localparam int FPL_DEBOUNCE_CYC = FPL_DEBOUNCE_US * FPL_CLK_MHZ;
    localparam int FPL_DB_W = 12;
endpackage

// [verification/fpl_core_model.sv]
`timescale 1ns/100ps
// processor core and program memory on the far side of the panel
module fpl_core_model
    import fpl_pkg::*;
(
    // clock and panel controls
    input wire logic clk_in,
    input wire fpl_mem_req_t req_in,
    input wire logic reset_in,
    input wire logic halt_in,
    input wire logic clk_en_in,
    // core outputs
    output logic flag_out,
    output logic strobe_out,
    output logic [7:0] out_data_out,
    output logic valid_out,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [256];
    logic [7:0] pc = 8'h00;
    logic [1:0] rd_pipe = 2'b00;
    logic [7:0] rd_addr = 8'h00;
    initial
    begin
        flag_out = 1'b0;
        strobe_out = 1'b0;
        out_data_out = 8'h00;
        valid_out = 1'b0;
        rdata_out = 8'h00;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'h00;
    end
    ////////////////////////////////////////
    // memory answers reads three cycles late, idle data keeps moving
    always @(posedge clk_in)
    begin
        valid_out <= rd_pipe[1];
        rdata_out <= rd_pipe[1] ? mem[rd_addr] : ~rdata_out;
        rd_pipe <= {rd_pipe[0], req_in.req & ~req_in.write};
        if (req_in.req)
            rd_addr <= req_in.addr[7:0];
        if (req_in.req && req_in.write)
            mem[req_in.addr[7:0]] <= req_in.data;
        strobe_out <= 1'b0;
        out_data_out <= ~out_data_out;
        if (reset_in)
        begin
            pc <= 8'h00;
            flag_out <= 1'b0;
        end
        else if (!halt_in && clk_en_in)
        begin
            pc <= pc + 8'h01;
            if (pc == 8'h00)
            begin
                strobe_out <= 1'b1;
                out_data_out <= mem[0];
                flag_out <= 1'b1;
            end
        end
    end
endmodule

// [verification/fpl_panel_tb.sv]
`timescale 1ns/100ps
`define FPL_CHK(a, b) \
    checks_done++; \
    if ((a) !== (b)) \
    begin \
        bad_count++; \
        $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); \
    end
module fpl_panel_tb
    import fpl_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic clr = 1'b0, ld = 1'b1, dir = 1'b1, btn = 1'b0, gate = 1'b1;
    logic lamp_n = 1'b0, gpio = 1'b0, got;
    logic [7:0] sw = 8'h00, lamps, gpio_out;
    logic flag, s_out, valid, rst_c, halt, clk_en, oe_n, flag_lamp;
    logic [7:0] s_data, rdata;
    logic [15:0] r0;
    fpl_mem_req_t req;
    fpl_mode_t mode;
    int bad_count = 0, checks_done = 0, cycles = 0;
    logic [7:0] bytes [3] = '{8'h7B, 8'h7A, 8'h30};
    fpl_panel u_fpl_panel (.clk_in(clk_in), .rst_in(rst_in),
        .clear_mode_switch_in(clr), .load_mode_switch_in(ld),
        .direction_switch_in(dir), .entry_pushbutton_in(btn),
        .byte_entry_switches_in(sw), .clock_gate_in(gate),
        .lamp_enable_n_in(lamp_n), .gpio_mode_in(gpio),
        .core_flag_in(flag), .core_out_strobe_in(s_out),
        .core_out_data_in(s_data), .mem_rdata_valid_in(valid),
        .mem_rdata_in(rdata), .core_reset_out(rst_c), .core_halt_out(halt),
        .core_clk_en_out(clk_en), .mem_req_out(req),
        .byte_display_lamps_out(lamps), .flag_lamp_out(flag_lamp),
        .connector_gpio_out(gpio_out), .connector_gpio_oe_n_out(oe_n),
        .mode_out(mode), .register_zero_out(r0));
    fpl_core_model u_fpl_core_model (.clk_in(clk_in), .req_in(req),
        .reset_in(rst_c), .halt_in(halt), .clk_en_in(clk_en),
        .flag_out(flag), .strobe_out(s_out), .out_data_out(s_data),
        .valid_out(valid), .rdata_out(rdata));
    ////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            complete_run();
        end
    end
    task complete_run();
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task set_mode(input logic c, input logic l);
        @(negedge clk_in);
        clr = c;
        ld = l;
        repeat (3) @(negedge clk_in);
    endtask
    // press, wait for a request, release and let the debounce settle
    task press(input logic [7:0] b, output logic seen);
        int n;
        n = 0;
        sw = b;
        btn = 1'b1;
        while (req.req !== 1'b1 && n < 3000)
        begin
            @(negedge clk_in);
            n++;
        end
        seen = (n < 3000);
        repeat (8) @(negedge clk_in);
        btn = 1'b0;
        repeat (2600) @(negedge clk_in);
    endtask
    task t_modes();
        fpl_mode_t exp [4] = '{FPL_MODE_LOAD, FPL_MODE_CLEAR,
            FPL_MODE_WAIT, FPL_MODE_RUN};
        for (int i = 3; i >= 0; i--)
        begin
            set_mode(i[1], i[0]);
            `FPL_CHK(mode, exp[i])
            if (i == 2)
            begin
                `FPL_CHK(halt, 1'b1)
            end
        end
        set_mode(1'b0, 1'b1);
        `FPL_CHK({rst_c, flag_lamp, r0}, {2'b10, 16'h0000})
        `FPL_CHK({oe_n, gpio_out}, 9'h100)
    endtask
    task t_write();
        set_mode(1'b0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            press(bytes[i], got);
            `FPL_CHK(lamps, bytes[i])
            `FPL_CHK(r0, 16'(i + 1))
            `FPL_CHK(u_fpl_core_model.mem[i], bytes[i])
        end
        set_mode(1'b1, 1'b0);
        press(8'hFF, got);
        `FPL_CHK({got, r0}, {1'b0, 16'h0003})
    endtask
    task t_read();
        set_mode(1'b0, 1'b1);
        dir = 1'b0;
        set_mode(1'b0, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            press(8'h55, got);
            `FPL_CHK({lamps, r0}, {bytes[i], 16'(i + 1)})
        end
        lamp_n = 1'b1;
        gate = 1'b0;
        repeat (3) @(negedge clk_in);
        `FPL_CHK({lamps, clk_en}, 9'h000)
        lamp_n = 1'b0;
        gate = 1'b1;
    endtask
    task t_run();
        gpio = 1'b1;
        set_mode(1'b0, 1'b1);
        set_mode(1'b1, 1'b1);
        repeat (600) @(negedge clk_in);
        `FPL_CHK({lamps, gpio_out, oe_n}, {16'h7B7B, 1'b0})
        `FPL_CHK({flag_lamp, halt}, 2'b10)
        set_mode(1'b1, 1'b0);
        `FPL_CHK({halt, rst_c, flag_lamp, lamps}, {3'b101, 8'h7B})
        set_mode(1'b1, 1'b1);
        `FPL_CHK({halt, rst_c, flag_lamp, lamps}, {3'b001, 8'h7B})
    endtask
    initial
    begin
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        t_modes();
        t_write();
        t_read();
        t_run();
        complete_run();
    end
endmodule
